// [verilog/irq_prioritizer_pkg.sv]
package irq_prioritizer_pkg;

    // Widths of the flag set and of the priority ladder
    localparam int NUM_FLAGS = 24;
    localparam int NUM_LEVELS = 16;
    localparam int LEVEL_W = 4;
    localparam int ADDR_W = 16;

    // Positions of the sticky flags inside the flag vector
    localparam int F_EXT1 = 0;
    localparam int F_EXT2 = 1;
    localparam int F_KEYPAD = 2;
    localparam int F_LOOP = 3;
    localparam int F_DMA0 = 4;
    localparam int F_TCH0 = 7;
    localparam int F_TWRAP = 11;
    localparam int F_SPI_RX = 12;
    localparam int F_SPI_TX = 13;
    localparam int F_SPI_FAULT = 14;
    localparam int F_SPI_OVR = 15;
    localparam int F_SCI_TX = 16;
    localparam int F_SCI_DONE = 17;
    localparam int F_SCI_RX = 18;
    localparam int F_SCI_IDLE = 19;
    localparam int F_SCI_OVR = 20;
    localparam int F_SCI_NOISE = 21;
    localparam int F_SCI_FRAME = 22;
    localparam int F_SCI_PARITY = 23;
    localparam int FIRST_ENABLED = 3;
    localparam int DMA_CHANNELS = 3;
    localparam int TIMER_CHANNELS = 4;

    // Priority numbers, 0 is the most urgent
    localparam int LV_TRAP = 0;
    localparam int LV_EXT1 = 1;
    localparam int LV_LOOP = 2;
    localparam int LV_DMA = 3;
    localparam int LV_TCH0 = 4;
    localparam int LV_TWRAP = 8;
    localparam int LV_SPI_RX = 9;
    localparam int LV_SPI_TX = 10;
    localparam int LV_SCI_ERR = 11;
    localparam int LV_SCI_RX = 12;
    localparam int LV_SCI_TX = 13;
    localparam int LV_EXT2 = 14;
    localparam int LV_KEYPAD = 15;

    // Vector pairs descend from the top pair in steps of two bytes
    localparam logic [15:0] VECTOR_TOP = 16'hFFFC;

    // Idle line detection lengths in received one bits
    localparam logic [3:0] IDLE_SHORT = 4'hA;
    localparam logic [3:0] IDLE_LONG = 4'hB;

    // Reset values
    localparam logic [23:0] FLAGS_RESET = 24'h000000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [3:0] IDLE_RESET = 4'h0;

endpackage : irq_prioritizer_pkg

// [verilog/sticky_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_bank
    import irq_prioritizer_pkg::*;
#(
    parameter int WIDTH = NUM_FLAGS
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clear,
    output logic [WIDTH-1:0] o_flags
);

    // One sticky bit per source; a set in the clearing cycle wins
    for (genvar b = 0; b < WIDTH; b++) begin : g_flag
        always_ff @(posedge i_clock) begin
            if (i_reset) begin
                o_flags[b] <= FLAGS_RESET[b];
            end else if (i_set[b]) begin
                o_flags[b] <= 1'b1;
            end else if (i_clear[b]) begin
                o_flags[b] <= 1'b0;
            end
        end
    end

endmodule : sticky_flag_bank

`default_nettype wire

// [verilog/lowest_index_picker.sv]
`timescale 1ns/1ps
`default_nettype none

module lowest_index_picker
    import irq_prioritizer_pkg::*;
#(
    parameter int WIDTH = NUM_LEVELS,
    parameter int INDEX_W = LEVEL_W
) (
    input wire logic [WIDTH-1:0] i_request,
    output logic o_valid,
    output logic [INDEX_W-1:0] o_index
);

    // Scan from the top down so the lowest pending number wins
    always_comb begin
        o_valid = 1'b0;
        o_index = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (i_request[i]) begin
                o_valid = 1'b1;
                o_index = INDEX_W'(i);
            end
        end
    end

endmodule : lowest_index_picker

`default_nettype wire

// [verilog/cpu_interrupt_source_prioritizer.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_interrupt_source_prioritizer
    import irq_prioritizer_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    // CPU core
    input wire logic i_instr_done,
    input wire logic i_global_mask,
    input wire logic i_software_trap_instruction,
    output logic o_int_take,
    output logic o_set_global_mask,
    output logic [LEVEL_W-1:0] o_int_level,
    output logic [ADDR_W-1:0] o_vector_hi_addr,
    output logic [ADDR_W-1:0] o_vector_lo_addr,
    output logic [NUM_LEVELS-1:0] o_level_request,
    // Flags, clears and enables
    output logic [NUM_FLAGS-1:0] o_flags,
    input wire logic [NUM_FLAGS-1:0] i_flag_clear,
    input wire logic [NUM_FLAGS-1:FIRST_ENABLED] i_source_enable,
    // External request and keypad pins
    input wire logic i_ext_pin1_n,
    input wire logic i_ext_pin2_n,
    input wire logic [7:0] i_keypad_n,
    input wire logic i_ext_pin1_mask,
    input wire logic i_ext_pin2_mask,
    input wire logic i_keypad_mask,
    // Clock generator and DMA
    input wire logic i_pll_lock,
    input wire logic [DMA_CHANNELS-1:0] i_dma_block_end,
    input wire logic [DMA_CHANNELS-1:0] i_dma_loop_end,
    // Timer module
    input wire logic [15:0] i_timer_count,
    input wire logic [15:0] i_timer_modulo,
    input wire logic [TIMER_CHANNELS-1:0] i_timer_capture,
    input wire logic [TIMER_CHANNELS-1:0] i_timer_compare,
    // SPI
    input wire logic i_spi_rx_load,
    input wire logic i_spi_rx_read,
    input wire logic i_spi_tx_load,
    input wire logic i_spi_master,
    input wire logic i_spi_busy,
    input wire logic i_spi_select_n,
    input wire logic i_spi_select_fault_detect_enable,
    // SCI
    input wire logic i_sci_tx_load,
    input wire logic i_sci_tx_shift_empty,
    input wire logic i_sci_tx_data_empty,
    input wire logic i_sci_tx_break_idle,
    input wire logic i_sci_rx_load,
    input wire logic i_sci_rx_read,
    input wire logic i_sci_rx_bit_tick,
    input wire logic i_sci_rx_bit,
    input wire logic i_sci_long_char,
    input wire logic i_sci_noise,
    input wire logic i_sci_stop_sample,
    input wire logic i_sci_stop_bit,
    input wire logic i_sci_parity_check,
    input wire logic i_sci_parity_ok
);

    logic [10:0] pin_meta;
    logic [10:0] pin_sync;
    logic spi_select_prev;
    logic lock_prev;
    logic [15:0] timer_prev;
    logic spi_unread;
    logic sci_unread;
    logic [3:0] idle_count;
    logic [3:0] idle_target;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_gate;
    logic [NUM_FLAGS-1:0] gated;
    logic [NUM_LEVELS-1:0] level_req;
    logic [NUM_LEVELS-1:0] eligible;
    logic pick_valid;
    logic [LEVEL_W-1:0] pick_index;
    logic take_now;
    logic wrap_event;
    logic fault_event;
    logic idle_event;

    // Pins are asynchronous; only the second stage feeds any logic
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pin_meta <= 11'h7FF;
            pin_sync <= 11'h7FF;
        end else begin
            pin_meta <= {i_spi_select_n, i_keypad_n,
                         i_ext_pin2_n, i_ext_pin1_n};
            pin_sync <= pin_meta;
        end
    end

    // Previous values for edge and wrap detection
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            spi_select_prev <= 1'b1;
            lock_prev <= i_pll_lock; // No false change at release
            timer_prev <= COUNT_RESET;
        end else begin
            spi_select_prev <= pin_sync[10];
            lock_prev <= i_pll_lock;
            timer_prev <= i_timer_count;
        end
    end

    // Receive data held and not yet read, one tracker per serial port
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            spi_unread <= 1'b0;
        end else if (i_spi_rx_load) begin
            spi_unread <= 1'b1;
        end else if (i_spi_rx_read) begin
            spi_unread <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sci_unread <= 1'b0;
        end else if (i_sci_rx_load) begin
            sci_unread <= 1'b1;
        end else if (i_sci_rx_read) begin
            sci_unread <= 1'b0;
        end
    end

    // Run of received ones; saturates so a long idle fires only once
    assign idle_target = i_sci_long_char ? IDLE_LONG : IDLE_SHORT;
    assign idle_event = i_sci_rx_bit_tick && i_sci_rx_bit
                        && (idle_count == idle_target - 4'h1);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            idle_count <= IDLE_RESET;
        end else if (i_sci_rx_bit_tick) begin
            if (!i_sci_rx_bit) begin
                idle_count <= IDLE_RESET;
            end else if (idle_count != idle_target) begin
                idle_count <= idle_count + 4'h1;
            end
        end
    end

    // Counter passed its modulo value and came back to zero
    assign wrap_event = (timer_prev == i_timer_modulo)
                        && (i_timer_count == 16'h0000)
                        && (timer_prev != 16'h0000);

    // Slave: select rises mid-transfer; master: select seen low
    assign fault_event = i_spi_select_fault_detect_enable
        && ((!i_spi_master && i_spi_busy
             && pin_sync[10] && !spi_select_prev)
            || (i_spi_master && !pin_sync[10]));

    // Set conditions of every sticky flag
    always_comb begin
        flag_set = FLAGS_RESET;
        flag_set[F_EXT1] = !pin_sync[0];
        flag_set[F_EXT2] = !pin_sync[1];
        flag_set[F_KEYPAD] = !(&pin_sync[9:2]);
        flag_set[F_LOOP] = i_pll_lock != lock_prev;
        flag_set[F_DMA0 +: DMA_CHANNELS] =
            i_dma_block_end | i_dma_loop_end;
        flag_set[F_TCH0 +: TIMER_CHANNELS] =
            i_timer_capture | i_timer_compare;
        flag_set[F_TWRAP] = wrap_event;
        flag_set[F_SPI_RX] = i_spi_rx_load;
        flag_set[F_SPI_TX] = i_spi_tx_load;
        flag_set[F_SPI_FAULT] = fault_event;
        flag_set[F_SPI_OVR] = i_spi_rx_load && spi_unread;
        flag_set[F_SCI_TX] = i_sci_tx_load;
        flag_set[F_SCI_DONE] = i_sci_tx_shift_empty
            && i_sci_tx_data_empty && !i_sci_tx_break_idle;
        flag_set[F_SCI_RX] = i_sci_rx_load;
        flag_set[F_SCI_IDLE] = idle_event;
        flag_set[F_SCI_OVR] = i_sci_rx_load && sci_unread;
        flag_set[F_SCI_NOISE] = i_sci_noise;
        flag_set[F_SCI_FRAME] =
            i_sci_stop_sample && !i_sci_stop_bit;
        flag_set[F_SCI_PARITY] =
            i_sci_parity_check && !i_sci_parity_ok;
    end

    sticky_flag_bank #(
        .WIDTH(NUM_FLAGS)
    ) u_flags (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_set(flag_set),
        .i_clear(i_flag_clear),
        .o_flags(o_flags)
    );

    // Pin masks block when set; the other sources use plain enables
    assign flag_gate = {i_source_enable, !i_keypad_mask,
                        !i_ext_pin2_mask, !i_ext_pin1_mask};
    assign gated = o_flags & flag_gate;

    // Combine sources sharing a level into one request
    always_comb begin
        level_req = '0;
        level_req[LV_TRAP] = i_software_trap_instruction;
        level_req[LV_EXT1] = gated[F_EXT1];
        level_req[LV_LOOP] = gated[F_LOOP];
        level_req[LV_DMA] = |gated[F_DMA0 +: DMA_CHANNELS];
        level_req[LV_TCH0 +: TIMER_CHANNELS] =
            gated[F_TCH0 +: TIMER_CHANNELS];
        level_req[LV_TWRAP] = gated[F_TWRAP];
        level_req[LV_SPI_RX] = gated[F_SPI_RX] | gated[F_SPI_FAULT]
            | gated[F_SPI_OVR];
        level_req[LV_SPI_TX] = gated[F_SPI_TX];
        level_req[LV_SCI_ERR] = |gated[F_SCI_OVR +: 4];
        level_req[LV_SCI_RX] = gated[F_SCI_RX] | gated[F_SCI_IDLE];
        level_req[LV_SCI_TX] = gated[F_SCI_TX] | gated[F_SCI_DONE];
        level_req[LV_EXT2] = gated[F_EXT2];
        level_req[LV_KEYPAD] = gated[F_KEYPAD];
    end

    assign o_level_request = level_req;

    // Global mask removes every level except the trap instruction
    assign eligible = {level_req[NUM_LEVELS-1:1] & {(NUM_LEVELS-1)
                       {!i_global_mask}}, level_req[LV_TRAP]};

    lowest_index_picker #(
        .WIDTH(NUM_LEVELS),
        .INDEX_W(LEVEL_W)
    ) u_pick (
        .i_request(eligible),
        .o_valid(pick_valid),
        .o_index(pick_index)
    );

    // Boundary only, and never in the entry cycle before the mask lands
    assign take_now = i_instr_done && pick_valid && !o_int_take;

    // Entry pulse; the core sets its mask from it on the next edge
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_int_take <= 1'b0;
        end else begin
            o_int_take <= take_now;
        end
    end

    assign o_set_global_mask = o_int_take;

    // Winner and its vector pair hold until the next entry
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_int_level <= LEVEL_RESET;
            o_vector_hi_addr <= ADDR_RESET;
            o_vector_lo_addr <= ADDR_RESET;
        end else if (take_now) begin
            o_int_level <= pick_index;
            o_vector_hi_addr <= VECTOR_TOP
                - {11'h000, pick_index, 1'b0};
            o_vector_lo_addr <= VECTOR_TOP
                - {11'h000, pick_index, 1'b0} + 16'h0001;
        end
    end

    // Checks below watch inputs, outputs and state of this block
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    // Levels more urgent than the winner, seen at the entry edge
    logic [NUM_LEVELS-1:0] prior_eligible;
    logic [NUM_LEVELS-1:0] more_urgent;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            prior_eligible <= '0;
        end else begin
            prior_eligible <= eligible;
        end
    end

    assign more_urgent = prior_eligible
        & ((NUM_LEVELS'(1) << o_int_level) - NUM_LEVELS'(1));

    a_lowest_wins: assert property (
        o_int_take |-> more_urgent == '0
    ) else $error("a less urgent level was taken");

    a_vector_map: assert property (
        o_int_take |-> o_vector_hi_addr
            == VECTOR_TOP - {11'h000, o_int_level, 1'b0}
    ) else $error("vector pair does not match level");

    a_mask_blocks: assert property (
        i_instr_done && i_global_mask && !i_software_trap_instruction
        |=> !o_int_take
    ) else $error("masked request was taken");

    a_trap_taken: assert property (
        i_instr_done && i_software_trap_instruction
        |=> o_int_take && o_int_level == LEVEL_RESET
    ) else $error("trap instruction not taken at level 0");

    a_pin_latch: assert property (
        !pin_sync[0] && !pin_meta[0] |=> o_flags[F_EXT1] [*2]
    ) else $error("low pin did not hold its flag");

    a_loop_change: assert property (
        $changed(i_pll_lock) |=> o_flags[F_LOOP]
    ) else $error("lock change did not set flag");

    a_spi_overflow: assert property (
        i_spi_rx_load && spi_unread |=> o_flags[F_SPI_OVR]
    ) else $error("spi overflow missed");

    a_sci_framing: assert property (
        i_sci_stop_sample && !i_sci_stop_bit |=> o_flags[F_SCI_FRAME]
    ) else $error("framing error missed");

    a_idle_run: assert property (
        idle_event |=> o_flags[F_SCI_IDLE] && idle_count == idle_target
    ) else $error("idle run did not set flag");

    a_mask_on_entry: assert property (
        o_int_take |-> o_set_global_mask ##1 !o_set_global_mask
    ) else $error("entry did not pulse mask set");

    a_pair_order: assert property (
        o_int_take |-> o_vector_lo_addr == o_vector_hi_addr + 16'h0001
    ) else $error("vector low byte not above high byte");

    a_boundary_only: assert property (
        !$past(i_instr_done) |-> !o_int_take
    ) else $error("entry outside instruction boundary");

endmodule : cpu_interrupt_source_prioritizer

`default_nettype wire

// [test/cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic [3:0] i_gap,
    input wire logic i_trap_req,
    input wire logic i_return,
    input wire logic i_set_global_mask,
    output logic o_instr_done,
    output logic o_trap,
    output logic o_global_mask
);
    logic [4:0] count;
    logic trap_pend;
    logic fin;

    // No boundary in the entry cycle, or a second entry could slip in
    assign fin = i_run && count == 5'h00 && !i_set_global_mask;

    // Spacing between instruction ends, at least three cycles
    always_ff @(posedge i_clock) begin
        if (i_reset || i_set_global_mask) begin
            count <= 5'h02;
        end else if (count != 5'h00) begin
            count <= count - 5'h01;
        end else if (i_run) begin
            count <= {1'b0, i_gap} + 5'h02;
        end
    end

    // Boundary pulse, carrying a pending trap instruction with it
    always_ff @(posedge i_clock) begin
        o_instr_done <= !i_reset && fin;
        o_trap <= !i_reset && fin && (trap_pend || i_trap_req);
        trap_pend <= !i_reset && !fin && (trap_pend || i_trap_req);
    end

    // Reset and entry hold interrupts off; return from service lifts it
    always_ff @(posedge i_clock) begin
        if (i_reset || i_set_global_mask) begin
            o_global_mask <= 1'b1;
        end else if (i_return) begin
            o_global_mask <= 1'b0;
        end
    end
endmodule : cpu_core_model

`default_nettype wire

// [test/tb_cpu_interrupt_source_prioritizer.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    miscompares++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end

module tb_cpu_interrupt_source_prioritizer;
    import irq_prioritizer_pkg::*;
    int miscompares = 0;
    int n_compared = 0;
    logic i_clock, i_reset, run, trap_req, ret, lock, p1, p2;
    logic instr_done, trap, gmask, o_int_take, o_set_global_mask;
    logic [3:0] gap, o_int_level;
    logic [23:3] en;
    logic [23:0] clr, o_flags;
    logic [33:0] pl;
    logic [15:0] tmod, tcnt, o_vector_hi_addr, o_vector_lo_addr;
    logic [15:0] o_level_request;
    logic [7:0] kb;
    logic [2:0] msk;

    // Clock at 200 MHz
    always #2.5 i_clock = !i_clock;

    cpu_core_model u_core (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_run(run),
        .i_gap(gap),
        .i_trap_req(trap_req),
        .i_return(ret),
        .i_set_global_mask(o_set_global_mask),
        .o_instr_done(instr_done),
        .o_trap(trap),
        .o_global_mask(gmask)
    );

    // Select pin idles high; pl[33] pulls it low for the master fault case
    cpu_interrupt_source_prioritizer u_dut (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_instr_done(instr_done),
        .i_global_mask(gmask),
        .i_software_trap_instruction(trap),
        .o_int_take(o_int_take),
        .o_set_global_mask(o_set_global_mask),
        .o_int_level(o_int_level),
        .o_vector_hi_addr(o_vector_hi_addr),
        .o_vector_lo_addr(o_vector_lo_addr),
        .o_level_request(o_level_request),
        .o_flags(o_flags),
        .i_flag_clear(clr),
        .i_source_enable(en),
        .i_ext_pin1_n(p1),
        .i_ext_pin2_n(p2),
        .i_keypad_n(kb),
        .i_ext_pin1_mask(msk[0]),
        .i_ext_pin2_mask(msk[1]),
        .i_keypad_mask(msk[2]),
        .i_pll_lock(lock),
        .i_dma_block_end(pl[2:0]),
        .i_dma_loop_end(pl[5:3]),
        .i_timer_count(tcnt),
        .i_timer_modulo(tmod),
        .i_timer_capture(pl[9:6]),
        .i_timer_compare(pl[13:10]),
        .i_spi_rx_load(pl[14]),
        .i_spi_rx_read(pl[27]),
        .i_spi_tx_load(pl[15]),
        .i_spi_master(pl[30]),
        .i_spi_busy(pl[31]),
        .i_spi_select_n(!pl[33]),
        .i_spi_select_fault_detect_enable(pl[32]),
        .i_sci_tx_load(pl[16]),
        .i_sci_tx_shift_empty(pl[17]),
        .i_sci_tx_data_empty(pl[18]),
        .i_sci_tx_break_idle(pl[29]),
        .i_sci_rx_load(pl[19]),
        .i_sci_rx_read(pl[28]),
        .i_sci_rx_bit_tick(pl[20]),
        .i_sci_rx_bit(pl[21]),
        .i_sci_long_char(1'b0),
        .i_sci_noise(pl[22]),
        .i_sci_stop_sample(pl[23]),
        .i_sci_stop_bit(pl[25]),
        .i_sci_parity_check(pl[24]),
        .i_sci_parity_ok(pl[26])
    );

    task automatic step;
        @(posedge i_clock);
        #1;
    endtask : step

    // Priority number that each flag's source is served at
    function automatic logic [3:0] lv_of(input int k);
        case (k)
            0: return 4'h1;
            1: return 4'hE;
            2: return 4'hF;
            3: return 4'h2;
            4, 5, 6: return 4'h3;
            7, 8, 9, 10: return 4'(k - 3);
            11: return 4'h8;
            12, 14, 15: return 4'h9;
            13: return 4'hA;
            16, 17: return 4'hD;
            18, 19: return 4'hC;
            default: return 4'hB;
        endcase
    endfunction : lv_of

    // Waits for an entry, then checks level, vector pair and pulse width
    task automatic wait_take(input logic [3:0] e);
        int i;
        for (i = 0; i < 60 && o_int_take !== 1'b1; i++) step;
        `CHK(o_int_take, 1'b1)
        `CHK(o_set_global_mask, 1'b1)
        `CHK(o_int_level, e)
        `CHK(o_vector_hi_addr, 16'hFFFC - {11'h000, e, 1'b0})
        `CHK(o_vector_lo_addr, 16'hFFFD - {11'h000, e, 1'b0})
        step;
        `CHK(o_int_take, 1'b0)
    endtask : wait_take

    task automatic resume(input logic [3:0] e);
        ret = 1'b1;
        step;
        ret = 1'b0;
        wait_take(e);
    endtask : resume

    // Drives the set condition of one flag, then returns all to idle
    task automatic fire(input int k);
        int n;
        n = (k == 19) ? 10 : (k == 14) ? 3 : (k == 15 || k == 20) ? 2 : 1;
        case (k)
            3: lock = !lock;
            4, 5: pl[k - 4] = 1'b1;
            6: pl[5] = 1'b1;
            7, 8: pl[k - 1] = 1'b1;
            9, 10: pl[k + 3] = 1'b1;
            11: tcnt = 16'h0000;
            12: pl[14] = 1'b1;
            15: pl[14] = 1'b1;
            13: {pl[27], pl[15]} = 2'b11;
            14: pl[33:30] = 4'b1101;
            16: pl[16] = 1'b1;
            17: pl[18:17] = 2'b11;
            18: pl[19] = 1'b1;
            20: pl[19] = 1'b1;
            19: {pl[28], pl[21:20]} = 3'b111;
            21: pl[22] = 1'b1;
            22: pl[23] = 1'b1;
            default: pl[24] = 1'b1;
        endcase
        repeat (n - 1) step;
        if (k == 19) `CHK(o_flags[19], 1'b0)
        if (k == 15) `CHK(o_flags[15], 1'b0)
        if (k == 20) `CHK(o_flags[20], 1'b0)
        step;
        pl = '0;
        tcnt = tmod;
        step;
    endtask : fire

    // Pins: any keypad line or either request pin, mask 1 blocks
    task automatic t_pins;
        int p, f;
        for (p = 0; p < 10; p++) begin
            f = (p < 8) ? 2 : p - 8;
            if (p < 8) kb[p] = 1'b0; else if (p == 8) p1 = 1'b0; else p2 = 1'b0;
            repeat (3) step;
            `CHK(o_flags[f], 1'b1)
            `CHK(o_level_request[lv_of(f)], 1'b0)
            msk[f] = 1'b0;
            step;
            `CHK(o_level_request[lv_of(f)], 1'b1)
            kb = 8'hFF;
            p1 = 1'b1;
            p2 = 1'b1;
            msk = 3'b111;
            repeat (3) step;
            clr = '1;
            step;
            clr = '0;
            `CHK(o_flags[f], 1'b0)
        end
    endtask : t_pins

    // Every other source: flag, enable gating, entry; refusal while masked for the loop flag only
    task automatic t_sources;
        int k;
        for (k = 3; k < 24; k++) begin
            en = '0;
            fire(k);
            `CHK(o_flags[k], 1'b1)
            `CHK(o_level_request[lv_of(k)], 1'b0)
            en[k] = 1'b1;
            step;
            `CHK(o_level_request[lv_of(k)], 1'b1)
            run = 1'b1;
            if (k == 3) repeat (30) begin
                step;
                `CHK(o_int_take, 1'b0)
            end
            resume(lv_of(k));
            clr = '1;
            step;
            clr = '0;
            run = 1'b0;
        end
    endtask : t_sources

    // Several pending with a slow core: trap first, then by number
    task automatic t_priority;
        en = '1;
        gap = 4'h9;
        msk = 3'b000;
        p2 = 1'b0;
        fire(10);
        fire(4);
        p2 = 1'b1;
        run = 1'b1;
        trap_req = 1'b1;
        step;
        trap_req = 1'b0;
        wait_take(4'h0);
        resume(4'h3);
        clr[4] = 1'b1;
        step;
        clr = '0;
        resume(4'h7);
        clr[10] = 1'b1;
        step;
        clr = '0;
        resume(4'hE);
        clr = '1;
        step;
        clr = '0;
        run = 1'b0;
    endtask : t_priority

    task automatic close_out;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        i_clock = 1'b0;
        i_reset = 1'b1;
        {run, trap_req, ret, lock} = 4'h0;
        gap = 4'h0;
        en = '0;
        clr = '0;
        pl = '0;
        tmod = 16'h0005;
        tcnt = 16'h0005;
        kb = 8'hFF;
        {p1, p2} = 2'b11;
        msk = 3'b111;
        repeat (12) @(posedge i_clock);
        #1;
        i_reset = 1'b0;
        step;
        t_pins;
        t_sources;
        t_priority;
        close_out;
    end

    // Watchdog, well beyond the expected few hundred cycles
    initial begin
        #50000;
        miscompares++;
        close_out;
    end
endmodule : tb_cpu_interrupt_source_prioritizer

`default_nettype wire
